/* File: verilog/i2csr_regs.v */
`timescale 1ns/1ps
`include "i2csr_consts.vh"

module i2csr_regs (
  input wire clk,
  input wire nrst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Event pulses from the bit-level engine (same clock)
  input wire ev_start_gen,
  input wire ev_addr_sent,
  input wire ev_hdr_sent,
  input wire ev_tx_ack,
  input wire ev_rx_done,
  input wire [7:0] rx_byte,
  input wire ev_addr_match,
  input wire ev_gencall,
  input wire ev_nack,
  input wire ev_start_det,
  input wire ev_stop_det,
  input wire ev_arb_lost,
  input wire ev_misplaced,
  input wire rx_ack_slot,
  input wire in_tx_role,
  // Controls toward the engine
  output wire interface_on,
  output wire start_req,
  output wire stop_req,
  output wire ack_en,
  output wire scl_hold,
  output wire rx_ready,
  output reg tx_go,
  output reg [7:0] tx_byte,
  output reg scl_tick,
  output wire irq
);

  // ==========================================================
  // Registers and flags
  // ==========================================================
  reg [7:0] ctrl_r;
  reg [7:0] speed_r;
  reg [7:0] byte_buffer_r;
  reg event_pending_r;
  reg ten_bit_header_sent_r;
  reg sent_not_received_r;
  reg busy_r;
  reg byte_done_r;
  reg own_address_hit_r;
  reg controller_role_r;
  reg start_sent_flag_r;
  reg ack_failure_r;
  reg stop_seen_flag_r;
  reg lost_bus_contest_r;
  reg misplaced_condition_error_r;
  reg broadcast_address_seen_r;
  reg addr_phase_r;
  reg st1_seen_r;
  reg st2_seen_r;
  reg [8:0] div_cnt_r;

  wire pe;
  wire broadcast_call_allow;
  wire irq_allow;
  wire wr_ctrl;
  wire rd_st1;
  wire rd_st2;
  wire wr_speed;
  wire wr_data;
  wire rd_data;
  wire arb_lost_q;
  wire any_event;
  wire [7:0] status_one;
  wire [7:0] status_two;
  wire [6:0] scl_divider;
  wire fast_speed_select;
  wire [8:0] div_limit;

  // Address decode used by every access strobe
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign pe = ctrl_r[`I2CSR_CR_PE];
  assign broadcast_call_allow = ctrl_r[`I2CSR_CR_BROADCAST_CALL_ALLOW];
  assign irq_allow = ctrl_r[`I2CSR_CR_ITE];
  assign interface_on = pe;
  assign start_req = ctrl_r[`I2CSR_CR_START];
  assign stop_req = ctrl_r[`I2CSR_CR_STOP];
  assign ack_en = ctrl_r[`I2CSR_CR_ACK];
  assign wr_ctrl = reg_wr & hit(reg_addr, `I2CSR_OFS_CTRL);
  assign rd_st1 = reg_rd & hit(reg_addr, `I2CSR_OFS_ST1);
  assign rd_st2 = reg_rd & hit(reg_addr, `I2CSR_OFS_ST2);
  assign wr_speed = reg_wr & hit(reg_addr, `I2CSR_OFS_SPEED);
  assign wr_data = reg_wr & hit(reg_addr, `I2CSR_OFS_DATA);
  assign rd_data = reg_rd & hit(reg_addr, `I2CSR_OFS_DATA);

  // A master receiver does not arbitrate in its own acknowledge slot
  assign arb_lost_q = pe & ev_arb_lost &
    ~(controller_role_r & ~in_tx_role & rx_ack_slot); // R17

  // Summary of every tracked event
  assign any_event = pe & (ev_tx_ack | ev_rx_done | ev_addr_match | ev_start_gen |
    ev_nack | (ev_stop_det & ack_en & ~controller_role_r) | arb_lost_q | ev_misplaced |
    ev_hdr_sent | ev_addr_sent | (ev_gencall & broadcast_call_allow)); // R1

  assign status_one = {event_pending_r, ten_bit_header_sent_r, sent_not_received_r,
    busy_r, byte_done_r, own_address_hit_r, controller_role_r, start_sent_flag_r};
  assign status_two = {3'b000, ack_failure_r, stop_seen_flag_r, lost_bus_contest_r,
    misplaced_condition_error_r, broadcast_address_seen_r}; // R13

  // Clock hold: byte, hit, start, header and address-sent flags only;
  // the error flags deliberately leave the line free
  assign scl_hold = pe & (byte_done_r | own_address_hit_r | start_sent_flag_r |
    ten_bit_header_sent_r | addr_phase_r); // R9 R10 R14 R16 R18
  assign rx_ready = pe & ~byte_done_r; // R22
  assign irq = irq_allow & event_pending_r; // R23

  // ==========================================================
  // Register port: writes and one-cycle-late read data
  // ==========================================================
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= `I2CSR_RST_CTRL;
      speed_r <= `I2CSR_RST_SPEED;
      reg_rdata <= 8'h00;
    end else begin
      // Disable clears every control bit but the stop request
      if (wr_ctrl) begin
        ctrl_r <= {2'b00, reg_wdata[5:0]};
        if (!reg_wdata[`I2CSR_CR_PE])
          ctrl_r <= {7'h00, reg_wdata[`I2CSR_CR_STOP]} << `I2CSR_CR_STOP; // R24
      end else if (!pe) begin
        ctrl_r <= ctrl_r & (8'h01 << `I2CSR_CR_STOP); // R24
      end else if (ev_start_gen) begin
        ctrl_r[`I2CSR_CR_START] <= 1'b0;
      end
      // Speed setting is kept across disable
      if (wr_speed)
        speed_r <= reg_wdata; // R20
      // Unmapped addresses read as zero
      if (reg_rd) begin
        case (reg_addr)
          `I2CSR_OFS_CTRL: reg_rdata <= ctrl_r;
          `I2CSR_OFS_ST1: reg_rdata <= status_one;
          `I2CSR_OFS_ST2: reg_rdata <= status_two;
          `I2CSR_OFS_SPEED: reg_rdata <= speed_r;
          `I2CSR_OFS_DATA: reg_rdata <= byte_buffer_r;
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Data byte and transmit kick
  // ==========================================================
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      byte_buffer_r <= `I2CSR_RST_DATA;
      tx_byte <= 8'h00;
      tx_go <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      if (wr_data) begin
        byte_buffer_r <= reg_wdata;
        tx_byte <= reg_wdata;
        tx_go <= pe & in_tx_role; // R21
      end else if (pe & ev_rx_done) begin
        byte_buffer_r <= rx_byte; // R22
      end
    end
  end

  // ==========================================================
  // Read-then-access sequence trackers
  // ==========================================================
  // A status read arms the tracker; the following data access consumes it, as does a control write for status one
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st1_seen_r <= 1'b0;
      st2_seen_r <= 1'b0;
    end else if (!pe) begin
      st1_seen_r <= 1'b0;
      st2_seen_r <= 1'b0;
    end else begin
      if (rd_st1)
        st1_seen_r <= 1'b1;
      else if (wr_data | rd_data | wr_ctrl)
        st1_seen_r <= 1'b0;
      if (rd_st2)
        st2_seen_r <= 1'b1;
      else if (wr_data | rd_data)
        st2_seen_r <= 1'b0;
    end
  end

  // ==========================================================
  // Status flags (an event in the clearing cycle wins)
  // ==========================================================
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      event_pending_r <= 1'b0;
      ten_bit_header_sent_r <= 1'b0;
      sent_not_received_r <= 1'b0;
      byte_done_r <= 1'b0;
      own_address_hit_r <= 1'b0;
      controller_role_r <= 1'b0;
      start_sent_flag_r <= 1'b0;
      ack_failure_r <= 1'b0;
      stop_seen_flag_r <= 1'b0;
      lost_bus_contest_r <= 1'b0;
      misplaced_condition_error_r <= 1'b0;
      broadcast_address_seen_r <= 1'b0;
      addr_phase_r <= 1'b0;
    end else if (!pe) begin
      // Disabled: status held in reset
      event_pending_r <= 1'b0; // R2 R24
      ten_bit_header_sent_r <= 1'b0;
      sent_not_received_r <= 1'b0; // R4
      byte_done_r <= 1'b0;
      own_address_hit_r <= 1'b0;
      controller_role_r <= 1'b0; // R11
      start_sent_flag_r <= 1'b0;
      ack_failure_r <= 1'b0; // R14
      stop_seen_flag_r <= 1'b0;
      lost_bus_contest_r <= 1'b0;
      misplaced_condition_error_r <= 1'b0;
      broadcast_address_seen_r <= 1'b0; // R19
      addr_phase_r <= 1'b0;
    end else begin
      // Summary flag: error clear by status two read
      if (any_event)
        event_pending_r <= 1'b1; // R1
      else if (rd_st2 | (~byte_done_r & ~own_address_hit_r & ~start_sent_flag_r &
               ~ten_bit_header_sent_r & ~addr_phase_r & ~ack_failure_r &
               ~stop_seen_flag_r & ~lost_bus_contest_r &
               ~misplaced_condition_error_r))
        event_pending_r <= 1'b0; // R2

      // Ten-bit header sent
      if (ev_hdr_sent)
        ten_bit_header_sent_r <= 1'b1; // R3
      else if (st2_seen_r & wr_data)
        ten_bit_header_sent_r <= 1'b0; // R3

      // Byte done: transmit and receive variants clear differently
      if (ev_tx_ack | ev_rx_done)
        byte_done_r <= 1'b1; // R7 R8
      else if (st1_seen_r & ((wr_data & sent_not_received_r) |
               (rd_data & ~sent_not_received_r)))
        byte_done_r <= 1'b0; // R7 R8

      // Direction flag follows byte done
      if (ev_tx_ack)
        sent_not_received_r <= 1'b1; // R4
      else if (ev_rx_done | ev_stop_det | arb_lost_q)
        sent_not_received_r <= 1'b0; // R4
      else if (st1_seen_r & (wr_data | rd_data))
        sent_not_received_r <= 1'b0; // R4

      // Own address hit
      if (ev_addr_match | (ev_gencall & broadcast_call_allow))
        own_address_hit_r <= 1'b1; // R10
      else if (rd_st1)
        own_address_hit_r <= 1'b0; // R10

      // Role: start request makes master
      if (wr_ctrl & reg_wdata[`I2CSR_CR_START] & reg_wdata[`I2CSR_CR_PE])
        controller_role_r <= 1'b1; // R11
      else if (ev_stop_det | arb_lost_q)
        controller_role_r <= 1'b0; // R11 R16

      // Start generated
      if (ev_start_gen)
        start_sent_flag_r <= 1'b1; // R12
      else if (st1_seen_r & wr_data)
        start_sent_flag_r <= 1'b0; // R12

      // Address sent as master; released by status one read then control write
      if (ev_addr_sent)
        addr_phase_r <= 1'b1; // R7
      else if (st1_seen_r & wr_ctrl)
        addr_phase_r <= 1'b0;

      // Error and stop flags, all cleared by a status two read
      if (ev_nack)
        ack_failure_r <= 1'b1; // R14
      else if (rd_st2)
        ack_failure_r <= 1'b0; // R14
      if (ev_stop_det & ack_en & ~controller_role_r)
        stop_seen_flag_r <= 1'b1; // R15
      else if (rd_st2)
        stop_seen_flag_r <= 1'b0; // R15
      if (arb_lost_q)
        lost_bus_contest_r <= 1'b1; // R16
      else if (rd_st2)
        lost_bus_contest_r <= 1'b0;
      if (ev_misplaced)
        misplaced_condition_error_r <= 1'b1; // R18
      else if (rd_st2)
        misplaced_condition_error_r <= 1'b0; // R18

      // Broadcast call seen only when allowed
      if (ev_gencall & broadcast_call_allow)
        broadcast_address_seen_r <= 1'b1; // R19
      else if (ev_stop_det)
        broadcast_address_seen_r <= 1'b0; // R19
    end
  end

  // ==========================================================
  // Bus busy: left untouched while disabled
  // ==========================================================
  // Software must confirm idle before enabling in a multimaster system
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
    end else if (pe) begin // R6
      if (ev_start_det)
        busy_r <= 1'b1; // R5
      else if (ev_stop_det | ev_misplaced)
        busy_r <= 1'b0; // R5
    end
  end

  // ==========================================================
  // Bus clock tick generator
  // ==========================================================
  // Tick every (divider+1) cycles in fast mode, four times that in standard
  assign scl_divider = speed_r[`I2CSR_CCR_DIV_MSB:0];
  assign fast_speed_select = speed_r[`I2CSR_CCR_FAST];
  assign div_limit = fast_speed_select ? {2'b00, scl_divider} :
    ({2'b00, scl_divider} << `I2CSR_STD_SHIFT) + 9'h003; // R25

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_r <= 9'h000;
      scl_tick <= 1'b0;
    end else if (!pe) begin
      div_cnt_r <= 9'h000;
      scl_tick <= 1'b0;
    end else if (div_cnt_r >= div_limit) begin
      div_cnt_r <= 9'h000;
      scl_tick <= 1'b1; // R25
    end else begin
      div_cnt_r <= div_cnt_r + 9'h001;
      scl_tick <= 1'b0;
    end
  end

endmodule

/* File: verilog/i2csr_consts.vh */
`ifndef I2CSR_CONSTS_VH
`define I2CSR_CONSTS_VH
// How it works
// R1: Any tracked event sets event_pending.
// R2: Status two read or disable clears event_pending.
// R3: Header sent sets flag; two-read plus write clears.
// R4: Direction flag shows transmit while byte_done set.
// R5: Start sets busy; stop or bus error clears.
// R6: Busy frozen while disabled; software checks idle first.
// R7: Transmit byte_done after ack clock; one-read, write clears.
// R8: Receive byte_done after ack pulse; one-read, read clears.
// R9: Clock line held low while byte_done set.
// R10: Address hit sets flag, holds clock, one-read clears.
// R11: Start request sets master; stop, loss, disable clear.
// R12: Start generated sets flag; one-read, address write clears.
// R13: Top three bits of status two read zero.
// R14: No acknowledge sets failure flag; never holds clock.
// R15: Slave stop after acknowledge sets stop flag.
// R16: Arbitration loss sets flag, drops to slave.
// R17: No arbitration during master receive acknowledge bit.
// R18: Misplaced start/stop sets error; master resynchronises.
// R19: Broadcast address sets flag if allowed; stop clears.
// R20: Speed bit and divider survive disable.
// R21: Data write starts transmission in transmitter role.
// R22: Next byte received only after data read.
// R23: One interrupt: any flag with enable set.
// R24: Disable resets control except stop, and status except busy.
// R25: Fixed divider formula gives bus clock ticks.

// Register offsets
`define I2CSR_OFS_CTRL 8'h18
`define I2CSR_OFS_ST1 8'h19
`define I2CSR_OFS_ST2 8'h1a
`define I2CSR_OFS_SPEED 8'h1b
`define I2CSR_OFS_DATA 8'h1e

// Control register bit positions
`define I2CSR_CR_ITE 0
`define I2CSR_CR_STOP 1
`define I2CSR_CR_ACK 2
`define I2CSR_CR_START 3
`define I2CSR_CR_BROADCAST_CALL_ALLOW 4
`define I2CSR_CR_PE 5

// Speed register fields
`define I2CSR_CCR_FAST 7
`define I2CSR_CCR_DIV_MSB 6

// Reset values
`define I2CSR_RST_CTRL 8'h00
`define I2CSR_RST_SPEED 8'h00
`define I2CSR_RST_DATA 8'h00

// Divider scaling: standard mode counts four times slower than fast mode
`define I2CSR_STD_SHIFT 2
`endif

/* File: testbench/i2csr_checker.sv */
`timescale 1ns/1ps
module i2csr_checker (
  input logic clk,
  input logic nrst,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic ev_start_gen,
  input logic ev_addr_sent,
  input logic ev_hdr_sent,
  input logic ev_tx_ack,
  input logic ev_rx_done,
  input logic ev_addr_match,
  input logic ev_gencall,
  input logic ev_nack,
  input logic ev_arb_lost,
  input logic ev_misplaced,
  input logic in_tx_role,
  input logic interface_on,
  input logic start_req,
  input logic ack_en,
  input logic scl_hold,
  input logic rx_ready,
  input logic tx_go,
  input logic [7:0] tx_byte,
  input logic scl_tick,
  input logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========
  // Register port timing
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside reply cycle");
  top_zero_a: assert property ($past(reg_rd && reg_addr == 8'h1a) |-> reg_rdata[7:5] == 3'h0)
    else $error("status two top bits not zero");
  // ==========
  // Transmit start
  tx_cause_a: assert property (tx_go |->
    $past(reg_wr && reg_addr == 8'h1e && interface_on && in_tx_role))
    else $error("transmit pulse without data write");
  tx_byte_a: assert property ($past(reg_wr && reg_addr == 8'h1e) |-> tx_byte == $past(reg_wdata))
    else $error("transmit byte not the written one");
  // ==========
  // Clock stretching; a write in the same cycle could disable, so it is excluded
  btf_hold_a: assert property (interface_on && ev_tx_ack && !reg_wr |=> scl_hold && !rx_ready)
    else $error("no hold after transmit ack");
  hit_hold_a: assert property (interface_on && ev_addr_match && !reg_wr && !reg_rd |=> scl_hold)
    else $error("no hold after address hit");
  rx_wait_a: assert property (interface_on && ack_en && ev_rx_done && !reg_wr && !reg_rd
    |=> !rx_ready)
    else $error("receiver ready with byte pending");
  err_free_a: assert property (interface_on && !scl_hold && !reg_wr
    && (ev_nack || ev_arb_lost || ev_misplaced) && !(ev_start_gen || ev_addr_sent
    || ev_hdr_sent || ev_tx_ack || ev_rx_done || ev_addr_match || ev_gencall)
    |=> !scl_hold)
    else $error("error flag holds clock");
  start_clr_a: assert property (interface_on && start_req && ev_start_gen && !reg_wr
    |=> !start_req)
    else $error("start request not cleared");
  off_quiet_a: assert property (!interface_on && $past(!interface_on)
    |-> !irq && !scl_hold && !tx_go && !rx_ready)
    else $error("outputs active while disabled");
  tx_cov: cover property (tx_go);
  irq_cov: cover property (irq);
  tick_cov: cover property (scl_tick);
endmodule

bind i2csr_regs i2csr_checker chk_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ev_start_gen(ev_start_gen), .ev_addr_sent(ev_addr_sent), .ev_hdr_sent(ev_hdr_sent),
  .ev_tx_ack(ev_tx_ack), .ev_rx_done(ev_rx_done), .ev_addr_match(ev_addr_match),
  .ev_gencall(ev_gencall),
  .ev_nack(ev_nack), .ev_arb_lost(ev_arb_lost), .ev_misplaced(ev_misplaced),
  .in_tx_role(in_tx_role), .interface_on(interface_on), .start_req(start_req),
  .ack_en(ack_en), .scl_hold(scl_hold), .rx_ready(rx_ready), .tx_go(tx_go),
  .tx_byte(tx_byte), .scl_tick(scl_tick), .irq(irq));

/* File: testbench/i2csr_eng_model.sv */
`timescale 1ns/1ps
module i2csr_eng_model (
  input logic clk,
  input logic nrst,
  input logic go,
  input logic [3:0] sel,
  input logic [7:0] dat,
  input logic slot,
  input logic txr,
  output logic [11:0] ev,
  output logic [7:0] rx_byte,
  output logic rx_ack_slot,
  output logic in_tx_role
);
  // ==========
  // One event pulse per command; the byte lane flips when not carrying a byte
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ev <= 12'h000;
      rx_byte <= 8'h00;
      rx_ack_slot <= 1'b0;
      in_tx_role <= 1'b0;
    end else begin
      ev <= go ? (12'h001 << sel) : 12'h000;
      rx_byte <= (go && sel == 4'h4) ? dat : ~rx_byte;
      rx_ack_slot <= slot;
      in_tx_role <= txr;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, go = 0, slot = 0, txr = 0, rd_d = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, dat = 8'h00, b, sp;
  logic [3:0] sel = 4'h0;
  logic [11:0] ev;
  logic [7:0] rx_byte, reg_rdata, tx_byte;
  logic rx_ack_slot, in_tx_role, interface_on, start_req, stop_req, ack_en;
  logic scl_hold, rx_ready, tx_go, scl_tick, irq;
  integer failures = 0, checks_done = 0;
  logic [7:0] exp_q[$];
  logic [7:0] gap = 8'h00;
  logic [7:0] gap_exp;
  logic gap_ok = 0;
  string nam_q[$];
  always #10 clk = ~clk;
  i2csr_eng_model peer (.clk(clk), .nrst(nrst), .go(go), .sel(sel), .dat(dat), .slot(slot),
    .txr(txr), .ev(ev), .rx_byte(rx_byte), .rx_ack_slot(rx_ack_slot), .in_tx_role(in_tx_role));
  i2csr_regs uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_start_gen(ev[0]),
    .ev_addr_sent(ev[1]), .ev_hdr_sent(ev[2]), .ev_tx_ack(ev[3]), .ev_rx_done(ev[4]),
    .rx_byte(rx_byte), .ev_addr_match(ev[5]), .ev_gencall(ev[6]), .ev_nack(ev[7]),
    .ev_start_det(ev[8]), .ev_stop_det(ev[9]), .ev_arb_lost(ev[10]), .ev_misplaced(ev[11]),
    .rx_ack_slot(rx_ack_slot), .in_tx_role(in_tx_role), .interface_on(interface_on),
    .start_req(start_req), .stop_req(stop_req), .ack_en(ack_en), .scl_hold(scl_hold),
    .rx_ready(rx_ready), .tx_go(tx_go), .tx_byte(tx_byte), .scl_tick(scl_tick), .irq(irq));
  // ==========
  // Shared tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  // Expected read data is queued here and matched by the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    exp_q.push_back(e);
    nam_q.push_back(n);
    @(posedge clk);
    reg_rd <= 0;
  endtask
  // Two idle edges let the flag land before the next access
  task automatic pulse(input logic [3:0] s);
    @(posedge clk);
    go <= 1;
    sel <= s;
    @(posedge clk);
    go <= 0;
    repeat (2) @(posedge clk);
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d && exp_q.size() > 0) chk(nam_q.pop_front(), exp_q.pop_front(), reg_rdata);
    rd_d <= reg_rd;
  end
  // Tick spacing from the speed setting: fast is divider+1, standard divider*4+4
  assign gap_exp = sp[7] ? {5'h00, sp[2:0]} + 8'h01 : {3'h0, sp[2:0], 2'b00} + 8'h04;
  // Only an unbroken enabled stretch is measured; the first tick just arms it
  always @(posedge clk) begin
    if (!interface_on) begin
      gap <= 8'h00;
      gap_ok <= 0;
    end else if (scl_tick) begin
      if (gap_ok) chk("tick_gap", gap_exp, gap);
      gap <= 8'h01;
      gap_ok <= 1;
    end else begin
      gap <= gap + 8'h01;
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out;
  end
  // ==========
  // Main sequence
  initial begin
    b = $urandom(32'h9c37);
    repeat (6) @(posedge clk);
    nrst <= 1;
    rd(8'h19, 8'h00, "st1");
    rd(8'h1a, 8'h00, "st2");
    rd(8'h1e, 8'h00, "data");
    rd(8'h1c, 8'h00, "unmapped");
    rd(8'h1b, 8'h00, "speed");
    // Small dividers keep several ticks inside the enabled stretch
    sp = 8'($urandom) & 8'h87;
    wr(8'h1b, sp);
    rd(8'h1b, sp, "speed");
    rd(8'h19, 8'h00, "st1");
    wr(8'h18, 8'h35);
    wr(8'h18, 8'h35);
    txr <= 1;
    // Master transmit
    wr(8'h18, 8'h3d);
    pulse(8);
    pulse(0);
    #1 chk("irq", 8'h01, {7'h0, irq});
    chk("start_req", 8'h00, {7'h0, start_req});
    rd(8'h19, 8'h93, "st1");
    b = 8'($urandom);
    wr(8'h1e, b);
    #1 chk("tx_go", 8'h01, {7'h0, tx_go});
    chk("tx_byte", b, tx_byte);
    pulse(1);
    rd(8'h19, 8'h92, "st1");
    wr(8'h18, 8'h35);
    rd(8'h19, 8'h12, "st1");
    pulse(3);
    #1 chk("scl_hold", 8'h01, {7'h0, scl_hold});
    rd(8'h19, 8'hba, "st1");
    wr(8'h1e, 8'hff);
    rd(8'h19, 8'h12, "st1");
    // Master receive
    txr <= 0;
    b = 8'($urandom);
    dat <= b;
    pulse(4);
    #1 chk("rx_ready", 8'h00, {7'h0, rx_ready});
    rd(8'h19, 8'h9a, "st1");
    rd(8'h1e, b, "data");
    #1 chk("rx_ready", 8'h01, {7'h0, rx_ready});
    // Errors, then a repeated start to resynchronise
    pulse(7);
    pulse(11);
    #1 chk("scl_hold", 8'h00, {7'h0, scl_hold});
    rd(8'h1a, 8'h12, "st2");
    rd(8'h19, 8'h02, "st1");
    wr(8'h18, 8'h3d);
    pulse(8);
    pulse(0);
    rd(8'h19, 8'h93, "st1");
    wr(8'h1e, 8'h00);
    // Arbitration during the acknowledge slot is ignored
    slot <= 1;
    pulse(10);
    rd(8'h1a, 8'h00, "st2");
    slot <= 0;
    pulse(10);
    rd(8'h19, 8'h90, "st1");
    rd(8'h1a, 8'h04, "st2");
    // Slave addressed by broadcast
    pulse(6);
    pulse(5);
    rd(8'h19, 8'h94, "st1");
    rd(8'h1a, 8'h01, "st2");
    pulse(9);
    rd(8'h1a, 8'h08, "st2");
    rd(8'h19, 8'h00, "st1");
    pulse(2);
    rd(8'h19, 8'hc0, "st1");
    rd(8'h1a, 8'h00, "st2");
    wr(8'h1e, 8'h00);
    rd(8'h19, 8'h00, "st1");
    // Disable with a byte pending
    pulse(4);
    wr(8'h18, 8'h02);
    pulse(8);
    rd(8'h19, 8'h00, "st1");
    rd(8'h1b, sp, "speed");
    #1 chk("irq", 8'h00, {7'h0, irq});
    chk("stop_req", 8'h01, {7'h0, stop_req});
    chk("ack_en", 8'h00, {7'h0, ack_en});
    repeat (3) @(posedge clk);
    close_out;
  end
endmodule
